/* File: bench/pfta_adapter_bench.sv */
// Self-checking bench for the processor FIFO test adapter
`timescale 1ns/1ps
module pfta_adapter_bench;
    import pfta_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic tb_sel_in = 1'b0;
    logic [ADDR_W-1:0] tb_addr_in = 7'h00;
    logic tb_wr_in = 1'b0;
    logic tb_rd_in = 1'b0;
    logic [TB_W-1:0] tb_wdata_in = 16'h0000;
    logic [TB_W-1:0] tb_rdata_out;
    logic tb_ack_out, proc_irq_out, link_data_oe_n_out, link_clk_out, link_strobe_out;
    logic [IRQ_W-1:0] link_irq_in;
    logic [WORD_W-1:0] link_data_in, link_data_out;
    logic [CMD_W-1:0] link_cmd_out;
    logic ready = 1'b0;
    logic attn = 1'b0;
    logic [31:0] status = 32'hC3A55A3C;
    int bad_count = 0;
    int check_count = 0;

    pfta_adapter uut (.clk_in(clk_in), .rst_in(rst_in), .tb_sel_in(tb_sel_in),
        .tb_addr_in(tb_addr_in), .tb_wr_in(tb_wr_in), .tb_rd_in(tb_rd_in),
        .tb_wdata_in(tb_wdata_in), .tb_rdata_out(tb_rdata_out), .tb_ack_out(tb_ack_out),
        .proc_irq_out(proc_irq_out), .link_irq_in(link_irq_in), .link_data_in(link_data_in),
        .link_data_out(link_data_out), .link_data_oe_n_out(link_data_oe_n_out),
        .link_clk_out(link_clk_out), .link_cmd_out(link_cmd_out),
        .link_strobe_out(link_strobe_out));
    pfta_proc_model proc (.link_clk_in(link_clk_out), .link_data_in(link_data_out),
        .link_data_oe_n_in(link_data_oe_n_out), .ready_in(ready), .attn_in(attn),
        .status_in(status), .link_data_out(link_data_in), .link_irq_out(link_irq_in));

    initial begin
        forever #10 clk_in = ~clk_in;
    end

    task automatic finish_test();
        if (bad_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_word(what, {31'h0, exp}, {31'h0, got});
    endtask : chk_bit

    // Request held until ack is seen, then dropped in that same cycle
    task automatic bus(input logic [6:0] a, input logic w, input logic [15:0] d,
                       output logic [15:0] q);
        int n;
        n = 0;
        tb_sel_in <= 1'b1;
        tb_addr_in <= a;
        tb_wr_in <= w;
        tb_rd_in <= !w;
        tb_wdata_in <= d;
        do begin
            @(negedge clk_in);
            n++;
        end while (tb_ack_out !== 1'b1 && n < 400);
        q = tb_rdata_out;
        chk_bit("bus ack", 1'b1, tb_ack_out);
        tb_sel_in <= 1'b0;
        tb_wr_in <= 1'b0;
        tb_rd_in <= 1'b0;
        @(negedge clk_in);
    endtask : bus

    task automatic send(input logic [31:0] w);
        logic [15:0] q;
        bus(ADDR_WORD_LO, 1'b1, w[15:0], q);
        bus(ADDR_WORD_HI, 1'b1, w[31:16], q);
    endtask : send

    // Intercepts written before the retrigger must still leave after it
    task automatic look_test();
        logic [31:0] w[5];
        w[0] = {KIND_START, 28'h0A1B2C3};
        w[1] = {KIND_INTERCEPT, 28'h1D2E3F4};
        w[2] = {KIND_INTERCEPT, 28'h2F0E1D2};
        w[3] = {KIND_RETRIG, 28'h3C4B5A6};
        w[4] = {KIND_END, 28'h4E5D6C7};
        for (int i = 0; i < 5; i++) send(w[i]);
        repeat (60) @(negedge clk_in);
        chk_word("sent before ready", 32'h2, 32'(proc.rx_q.size()));
        chk_word("start word", w[0], proc.rx_q[0]);
        chk_word("retrigger word", w[3], proc.rx_q[1]);
        ready <= 1'b1;
        repeat (80) @(negedge clk_in);
        chk_word("words sent", 32'h5, 32'(proc.rx_q.size()));
        chk_word("intercept 1", w[1], proc.rx_q[2]);
        chk_word("intercept 2", w[2], proc.rx_q[3]);
        chk_word("end marker", w[4], proc.rx_q[4]);
        chk_bit("link released", 1'b1, link_data_oe_n_out);
    endtask : look_test

    task automatic cmd_test();
        logic [15:0] q;
        time t;
        bus(ADDR_CMD, 1'b1, 16'h000B, q);
        chk_word("command lines", 32'hB, {28'h0, link_cmd_out});
        chk_bit("strobe c2", 1'b1, link_strobe_out);
        repeat (2) @(negedge clk_in);
        chk_bit("strobe c4", 1'b1, link_strobe_out);
        @(negedge clk_in);
        chk_bit("strobe c5", 1'b0, link_strobe_out);
        // A second command while the strobe stands must wait for it to drop
        bus(ADDR_CMD, 1'b1, 16'h0006, q);
        t = $time;
        bus(ADDR_CMD, 1'b1, 16'h0009, q);
        chk_word("refused command span", 32'(5 * CLK_PERIOD_NS), 32'($time - t));
        chk_word("command lines 2", 32'h9, {28'h0, link_cmd_out});
        chk_bit("strobe 2", 1'b1, link_strobe_out);
    endtask : cmd_test

    task automatic status_test();
        logic [15:0] q;
        bus(ADDR_STATUS, 1'b0, 16'h0000, q);
        chk_word("status low", {16'h0, status[15:0]}, {16'h0, q});
        bus(ADDR_STATUS, 1'b0, 16'h0000, q);
        chk_word("status high", {16'h0, status[31:16]}, {16'h0, q});
        bus(7'h55, 1'b0, 16'h0000, q);
        chk_word("unmapped read", 32'h0, {16'h0, q});
    endtask : status_test

    task automatic irq_test();
        attn <= 1'b1;
        repeat (2) @(negedge clk_in);
        chk_bit("irq early", 1'b0, proc_irq_out);
        @(negedge clk_in);
        chk_bit("irq raised", 1'b1, proc_irq_out);
    endtask : irq_test

    initial begin
        repeat (8) @(negedge clk_in);
        chk_bit("oe_n in reset", 1'b1, link_data_oe_n_out);
        rst_in <= 1'b0;
        @(negedge clk_in);
        look_test();
        cmd_test();
        status_test();
        irq_test();
        finish_test();
    end

    // The tests need about 200 cycles; this is far beyond that
    initial begin
        #100000;
        bad_count++;
        finish_test();
    end
endmodule : pfta_adapter_bench

/* File: bench/pfta_proc_model.sv */
// Processor-side model: takes link words, answers with status and irq lines
`timescale 1ns/1ps
module pfta_proc_model (
    input wire logic link_clk_in,
    input wire logic [31:0] link_data_in,
    input wire logic link_data_oe_n_in,
    input wire logic ready_in,
    input wire logic attn_in,
    input wire logic [31:0] status_in,
    output logic [31:0] link_data_out,
    output logic [1:0] link_irq_out
);
    logic [31:0] rx_q[$];
    // Words are taken on the rising link clock only
    always @(posedge link_clk_in) begin
        rx_q.push_back(link_data_in);
    end
    // Status only while the adapter has let go of the link, never a stale copy
    assign link_data_out = link_data_oe_n_in ? status_in : ~status_in;
    assign link_irq_out = {attn_in, ready_in};
endmodule : pfta_proc_model

/* File: logic/pfta_adapter.sv */
// Test adapter moving pulse words to the processor over the differential link
`timescale 1ns/1ps
// Function
// - Start header goes from test bus through latches onto the differential link.
// - Bus-side steering enables are generated internally from select, address, read/write strobes and word kind bits; FIFO pop waits for processor ready.
// - Intercept words are held in a FIFO so retrigger words go first.
// - Held intercept word is sent from FIFO by the header path when processor ready.
// - Retrigger words use the same route and timing as the start header.
// - An end marker closes each look after all other words.
// - Bits 31:28 of each outgoing word steer how the word flows.
// - Low 16 bits from the internal bus load a command buffer; its low four bits drive the command lines.
// - Status low half returns through a latch toward the bus controller.
// - Status upper half is held and later given on the low 16 lines.
// - Seven address bits plus select are decoded into controls and bus acknowledge.
// - Four command lines, a command strobe and a clock drive the processor.
// - Processor interrupt lines are received; the attention line alone yields an interrupt to test bus.
module pfta_adapter #(
    parameter int FIFO_DEPTH = pfta_pkg::FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic tb_sel_in,
    input wire logic [pfta_pkg::ADDR_W-1:0] tb_addr_in,
    input wire logic tb_wr_in,
    input wire logic tb_rd_in,
    input wire logic [pfta_pkg::TB_W-1:0] tb_wdata_in,
    output logic [pfta_pkg::TB_W-1:0] tb_rdata_out,
    output logic tb_ack_out,
    output logic proc_irq_out,
    input wire logic [pfta_pkg::IRQ_W-1:0] link_irq_in,
    input wire logic [pfta_pkg::WORD_W-1:0] link_data_in,
    output logic [pfta_pkg::WORD_W-1:0] link_data_out,
    output logic link_data_oe_n_out,
    output logic link_clk_out,
    output logic [pfta_pkg::CMD_W-1:0] link_cmd_out,
    output logic link_strobe_out
);
    import pfta_pkg::*;

    typedef struct packed {
        pfta_tx_t st;
        logic [CNT_W-1:0] cnt;
        logic [WORD_W-1:0] tx;
        logic oe_n;
        logic lclk;
        logic [CMD_W-1:0] cmd;
        logic [TB_W-1:0] ctl_buf;
        logic strobe;
        logic [CNT_W-1:0] strb_cnt;
        logic [TB_W-1:0] lo;
        logic [WORD_W-1:0] direct_word;
        logic direct_pend;
        logic [WORD_W-1:0] end_word;
        logic end_pend;
        logic [TB_W-1:0] rdata;
        logic ack;
        logic [TB_W-1:0] hi_buf;
        logic hi_held;
        logic [IRQ_W-1:0] irq_s1;
        logic [IRQ_W-1:0] irq_s2;
        logic [WORD_W-1:0] dat_s1;
        logic [WORD_W-1:0] dat_s2;
        logic irq_out;
    } pfta_state_t;

    pfta_state_t r;
    pfta_state_t n;
    logic req;
    logic [3:0] kind;
    logic fifo_push;
    logic fifo_pop;
    logic fifo_full;
    logic fifo_empty;
    logic [WORD_W-1:0] fifo_dout;

    pfta_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_hold (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .push_in(fifo_push),
        .data_in({tb_wdata_in, r.lo}),
        .pop_in(fifo_pop),
        .data_out(fifo_dout),
        .full_out(fifo_full),
        .empty_out(fifo_empty)
    );

    // Strobes are levels held by the controller until it sees the ack
    assign req = tb_sel_in && (tb_wr_in || tb_rd_in) && !r.ack;
    assign kind = tb_wdata_in[KIND_MSB:KIND_LSB];

    always_comb begin
        n = r;
        n.ack = 1'b0;
        fifo_push = 1'b0;
        fifo_pop = 1'b0;
        // Link inputs come from another domain; two stages before use
        n.irq_s1 = link_irq_in;
        n.irq_s2 = r.irq_s1;
        n.dat_s1 = link_data_in;
        n.dat_s2 = r.dat_s1;
        n.irq_out = r.irq_s2[IRQ_ATTN];
        if (r.strobe) begin
            if (r.strb_cnt == CNT_ZERO) begin
                n.strobe = 1'b0;
            end else begin
                n.strb_cnt = r.strb_cnt - 1'b1;
            end
        end
        case (r.st)
            TX_IDLE: begin
                if (r.direct_pend) begin
                    n.tx = r.direct_word;
                    n.direct_pend = 1'b0;
                    n.st = TX_SETUP;
                end else if (!fifo_empty && r.irq_s2[IRQ_READY]) begin
                    n.tx = fifo_dout;
                    fifo_pop = 1'b1;
                    n.st = TX_SETUP;
                end else if (r.end_pend && fifo_empty) begin
                    n.tx = r.end_word;
                    n.end_pend = 1'b0;
                    n.st = TX_SETUP;
                end
                if (n.st == TX_SETUP) begin
                    n.oe_n = 1'b0;
                    n.cnt = HALF_LOAD;
                end
            end
            TX_SETUP: begin
                if (r.cnt == CNT_ZERO) begin
                    n.st = TX_HIGH;
                    n.lclk = 1'b1;
                    n.cnt = HALF_LOAD;
                end else begin
                    n.cnt = r.cnt - 1'b1;
                end
            end
            TX_HIGH: begin
                if (r.cnt == CNT_ZERO) begin
                    n.st = TX_HOLD;
                    n.lclk = 1'b0;
                    n.cnt = HALF_LOAD;
                end else begin
                    n.cnt = r.cnt - 1'b1;
                end
            end
            TX_HOLD: begin
                // Hold data past the falling edge so the processor sees no skew
                if (r.cnt == CNT_ZERO) begin
                    n.st = TX_IDLE;
                    n.oe_n = 1'b1;
                end else begin
                    n.cnt = r.cnt - 1'b1;
                end
            end
            default: begin
                n.st = TX_IDLE;
                n.oe_n = 1'b1;
                n.lclk = 1'b0;
            end
        endcase
        if (req && tb_wr_in) begin
            case (tb_addr_in)
                ADDR_WORD_LO: begin
                    n.lo = tb_wdata_in;
                    n.ack = 1'b1;
                end
                ADDR_WORD_HI: begin
                    // Ack is withheld while the target slot is busy: back-pressure
                    if (kind == KIND_INTERCEPT) begin
                        if (!fifo_full) begin
                            fifo_push = 1'b1;
                            n.ack = 1'b1;
                        end
                    end else if (kind == KIND_END) begin
                        if (!r.end_pend) begin
                            n.end_word = {tb_wdata_in, r.lo};
                            n.end_pend = 1'b1;
                            n.ack = 1'b1;
                        end
                    end else if (!r.direct_pend && !r.end_pend) begin
                        n.direct_word = {tb_wdata_in, r.lo};
                        n.direct_pend = 1'b1;
                        n.ack = 1'b1;
                    end
                end
                ADDR_CMD: begin
                    if (!r.strobe) begin
                        n.ctl_buf = tb_wdata_in;
                        n.cmd = tb_wdata_in[CMD_W-1:0];
                        n.strobe = 1'b1;
                        n.strb_cnt = HALF_LOAD;
                        n.ack = 1'b1;
                    end
                end
                default: begin
                    n.ack = 1'b1;
                end
            endcase
        end else if (req && tb_rd_in) begin
            n.ack = 1'b1;
            if (tb_addr_in == ADDR_STATUS) begin
                if (r.hi_held) begin
                    n.rdata = r.hi_buf;
                    n.hi_held = 1'b0;
                end else begin
                    n.rdata = r.dat_s2[TB_W-1:0];
                    n.hi_buf = r.dat_s2[WORD_W-1:TB_W];
                    n.hi_held = 1'b1;
                end
            end else begin
                n.rdata = RDATA_ZERO;
            end
        end
        if (rst_in) begin
            n = '0;
            n.oe_n = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        r <= n;
    end

    assign tb_rdata_out = r.rdata;
    assign tb_ack_out = r.ack;
    assign proc_irq_out = r.irq_out;
    assign link_data_out = r.tx;
    assign link_data_oe_n_out = r.oe_n;
    assign link_clk_out = r.lclk;
    assign link_cmd_out = r.cmd;
    assign link_strobe_out = r.strobe;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_four_high(logic sig);
        sig [*4] ##1 !sig;
    endsequence

    a_drive_in_send: assert property ((r.st != TX_IDLE) |-> !link_data_oe_n_out)
        else $error("link not driven during send");
    a_clk_high_len: assert property ($rose(link_clk_out) |-> s_four_high(link_clk_out))
        else $error("link clock high phase wrong");
    a_strobe_len: assert property ($rose(link_strobe_out) |-> s_four_high(link_strobe_out))
        else $error("command strobe length wrong");
    a_data_stable: assert property ($rose(link_clk_out) |-> $stable(link_data_out) [*5])
        else $error("link data moved around clock");
    a_pop_ready: assert property (fifo_pop |-> r.irq_s2[IRQ_READY])
        else $error("FIFO word released without ready");
    a_pop_sends: assert property (fifo_pop |=> !link_data_oe_n_out
        && link_data_out == $past(fifo_dout))
        else $error("popped word not put on link");
    a_direct_first: assert property ((r.st == TX_IDLE) && r.direct_pend
        |=> link_data_out == $past(r.direct_word) && !link_data_oe_n_out)
        else $error("pending direct word not sent first");
    a_end_last: assert property ((r.st == TX_IDLE) && r.end_pend && !r.direct_pend
        && !fifo_empty |=> r.end_pend)
        else $error("end marker sent before FIFO drained");
    a_ack_pulse: assert property (tb_ack_out |=> !tb_ack_out)
        else $error("ack longer than one cycle");
    // A write raised together with a read wins, so only a pure read counts here
    a_status_first: assert property (req && tb_rd_in && !tb_wr_in
        && (tb_addr_in == ADDR_STATUS) && !r.hi_held
        |=> r.hi_held && tb_rdata_out == $past(r.dat_s2[TB_W-1:0]))
        else $error("status low half wrong");
    a_status_second: assert property (req && tb_rd_in && !tb_wr_in
        && (tb_addr_in == ADDR_STATUS) && r.hi_held
        |=> !r.hi_held && tb_rdata_out == $past(r.hi_buf))
        else $error("status upper half wrong");
endmodule : pfta_adapter

/* File: logic/pfta_fifo.sv */
// Holding FIFO for intercept words, first word falls through
`timescale 1ns/1ps
module pfta_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic push_in,
    input wire logic [WIDTH-1:0] data_in,
    input wire logic pop_in,
    output logic [WIDTH-1:0] data_out,
    output logic full_out,
    output logic empty_out
);
    // Depth must be a power of two; pointers carry one wrap bit
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } pfta_fifo_ptr_t;

    pfta_fifo_ptr_t r;
    pfta_fifo_ptr_t n;
    logic [WIDTH-1:0] mem [DEPTH];

    assign full_out = (r.wr[AW] != r.rd[AW]) && (r.wr[AW-1:0] == r.rd[AW-1:0]);
    assign empty_out = (r.wr == r.rd);
    assign data_out = mem[r.rd[AW-1:0]];

    always_comb begin
        n = r;
        if (push_in && !full_out) begin
            n.wr = r.wr + 1'b1;
        end
        if (pop_in && !empty_out) begin
            n.rd = r.rd + 1'b1;
        end
        if (rst_in) begin
            n = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        r <= n;
        if (push_in && !full_out && !rst_in) begin
            mem[r.wr[AW-1:0]] <= data_in;
        end
    end
endmodule : pfta_fifo

/* File: logic/pfta_pkg.sv */
// Constants and types shared by the processor FIFO test adapter
package pfta_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int LINK_HALF_NS = 80;
    localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] HALF_LOAD = CNT_W'(LINK_HALF_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    localparam int ADDR_W = 7;
    localparam int TB_W = 16;
    localparam int WORD_W = 32;
    localparam int CMD_W = 4;
    localparam int IRQ_W = 2;
    localparam int FIFO_DEPTH = 16;

    localparam logic [ADDR_W-1:0] ADDR_WORD_LO = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_WORD_HI = 7'h01;
    localparam logic [ADDR_W-1:0] ADDR_CMD = 7'h02;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 7'h03;

    // Word kind sits in bits 31:28, i.e. bits 15:12 of the upper half written
    localparam int KIND_MSB = 15;
    localparam int KIND_LSB = 12;
    localparam logic [3:0] KIND_START = 4'h1;
    localparam logic [3:0] KIND_RETRIG = 4'h2;
    localparam logic [3:0] KIND_INTERCEPT = 4'h3;
    localparam logic [3:0] KIND_END = 4'h4;

    localparam int IRQ_READY = 0;
    localparam int IRQ_ATTN = 1;
    localparam logic [TB_W-1:0] RDATA_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_SETUP,
        TX_HIGH,
        TX_HOLD
    } pfta_tx_t;
endpackage : pfta_pkg
